// ===== design/tci_pkg.sv
// Purpose: shared constants for the timer channel unit
// Assumes: 32-bit register port, byte addresses
// Notes: offsets, field positions and encodings live here only
`default_nettype none

package tci_pkg;
   // ======================================================
   // sizes
   localparam int TCI_CHANNELS = 4;        // channels in the unit
   localparam int TCI_CNT_W = 16;          // counter width
   localparam int TCI_ADDR_W = 8;          // register address width
   localparam int TCI_DATA_W = 32;         // register data width
   localparam int TCI_CLOCKS = 4;          // prescaled clocks

   // ======================================================
   // register offsets (byte addresses)
   localparam logic [7:0] TCI_START_OFS = 8'h00;     // start_trigger_register
   localparam logic [7:0] TCI_STOP_OFS = 8'h04;      // stop trigger, reads running flags
   localparam logic [7:0] TCI_LEVEL_OFS = 8'h08;     // output_level_register
   localparam logic [7:0] TCI_ENABLE_OFS = 8'h0c;    // output_enable_register
   localparam logic [7:0] TCI_POLARITY_OFS = 8'h10;  // output_polarity_register
   localparam logic [7:0] TCI_OMODE_OFS = 8'h14;     // output mode register
   localparam logic [7:0] TCI_FILTER_OFS = 8'h18;    // input filter enable register
   localparam logic [7:0] TCI_MODE_BASE = 8'h20;     // channel_mode_register n
   localparam logic [7:0] TCI_RELOAD_BASE = 8'h40;   // reload_value_register n
   localparam logic [7:0] TCI_COUNT_BASE = 8'h60;    // channel_counter n
   localparam logic [7:0] TCI_BANK_MASK = 8'he0;     // bank select bits
   localparam int TCI_IDX_LSB = 2;                   // channel index lsb

   // ======================================================
   // channel_mode_register fields
   localparam int TCI_CKS_HI = 15;         // operating clock select high bit
   localparam int TCI_CKS_LO = 14;         // operating clock select low bit
   localparam int TCI_CCS = 12;            // count_source_select
   localparam int TCI_STS_HI = 9;          // start_trigger_select_hi
   localparam int TCI_STS_LO = 8;          // start_trigger_select_lo
   localparam int TCI_MD_HI = 3;           // operation mode field high bit
   localparam int TCI_MD_LO = 1;           // operation mode field low bit
   localparam int TCI_SIS = 0;             // start_interrupt_select
   localparam logic [15:0] TCI_MODE_RESET = 16'h0000;

   // operation modes
   typedef enum logic [2:0]
   {
      TCI_MD_INTERVAL = 3'b000,
      TCI_MD_CAPTURE = 3'b010,
      TCI_MD_EVENT = 3'b011,
      TCI_MD_ONECOUNT = 3'b100
   } tci_mode_e;

   localparam logic [15:0] TCI_CNT_ZERO = 16'h0000;
   localparam logic [15:0] TCI_CNT_ONE = 16'h0001;
endpackage : tci_pkg

`default_nettype wire

// ===== design/tci_input_path.sv
// Purpose: timer input pin path: synchroniser, noise filter, edge detector
// Assumes: pin is asynchronous to i_clock
// Notes: held idle while the input is unused
`default_nettype none

module tci_input_path
   import tci_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_reset_n,
   input wire logic i_pin,          // timer_input_pin
   input wire logic i_active,       // input in use
   input wire logic i_filter_en,    // input_filter_enable
   output logic o_rise,             // accepted rising edge, pulse
   output logic o_fall              // accepted falling edge, pulse
);
   // ======================================================
   // state
   logic sync_a;     // first synchroniser stage
   logic sync_b;     // second synchroniser stage
   logic sample;     // previous synchronised sample
   logic level;      // accepted level
   logic level_d;    // accepted level, one cycle back

   // synchroniser, sample and filter; idle when input unused
   always_ff @(posedge i_clock or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         sync_a <= 1'b0;
         sync_b <= 1'b0;
         sample <= 1'b0;
         level <= 1'b0;
      end
      else if (!i_active)
      begin
         sync_a <= 1'b0;
         sync_b <= 1'b0;
         sample <= 1'b0;
         level <= 1'b0;
      end
      else
      begin
         sync_a <= i_pin;
         sync_b <= sync_a;
         sample <= sync_b;
         if (i_filter_en)
         begin
            if (sync_b == sample)
               level <= sample;
         end
         else
            level <= sync_b;
      end
   end

   // edge detector on the accepted level
   always_ff @(posedge i_clock or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         level_d <= 1'b0;
         o_rise <= 1'b0;
         o_fall <= 1'b0;
      end
      else
      begin
         level_d <= level;
         o_rise <= i_active & level & ~level_d;
         o_fall <= i_active & ~level & level_d;
      end
   end
endmodule : tci_input_path

`default_nettype wire

// ===== design/tci_timer_unit.sv
// Purpose: multi-channel timer with interval mode and output control
// Assumes: prescaled clocks arrive as one-cycle enables on i_clock
// Notes: registers over a plain strobe port, read data one cycle later
//
// Local design decisions: the register addresses and strobed register access.
`default_nettype none

module tci_timer_unit
   import tci_pkg::*;
#(
   parameter int CHANNELS = TCI_CHANNELS,
   parameter int CNT_W = TCI_CNT_W
)
(
   input wire logic i_clock,
   input wire logic i_reset_n,
   input wire logic [TCI_ADDR_W-1:0] i_addr,        // register address
   input wire logic [TCI_DATA_W-1:0] i_wr_data,     // register write data
   input wire logic i_wr_en,                        // write strobe
   input wire logic i_rd_en,                        // read strobe
   output logic [TCI_DATA_W-1:0] o_rd_data,         // read data
   input wire logic [TCI_CLOCKS-1:0] i_prescale_tick, // prescaled clock enables
   input wire logic [CHANNELS-1:0] i_timer_input_pin, // timer inputs
   output logic [CHANNELS-1:0] o_channel_output,    // output pins
   output logic [CHANNELS-1:0] o_channel_interrupt  // interrupt pulses
);
   // ======================================================
   // helper functions

   // operating clock enable for one channel
   function automatic logic sel_tick(input int ch, input logic [15:0] mode,
                                     input logic [TCI_CLOCKS-1:0] ticks);
      logic hi;
      logic lo;
      hi = mode[TCI_CKS_HI];
      lo = mode[TCI_CKS_LO];
      // four clocks on 1 and 3
      if ((ch % 2) == 0)
         lo = 1'b0;
      sel_tick = ticks[{lo, hi}];
   endfunction : sel_tick

   // master channel feeding a slave channel
   function automatic int master_of(input int ch);
      if ((ch % 2) == 1)
         master_of = ch - 1;
      else
         master_of = 0;
   endfunction : master_of

   // channel index for a banked register
   function automatic int bank_idx(input logic [TCI_ADDR_W-1:0] a);
      bank_idx = int'(a[TCI_IDX_LSB+2:TCI_IDX_LSB]);
   endfunction : bank_idx

   // operation mode field of a mode register
   function automatic logic [2:0] mode_of(input logic [15:0] m);
      mode_of = m[TCI_MD_HI:TCI_MD_LO];
   endfunction : mode_of

   // ======================================================
   // registers
   logic [CNT_W-1:0] channel_counter [CHANNELS];        // counters
   logic [CNT_W-1:0] reload_value_register [CHANNELS];  // reload values
   logic [15:0] channel_mode_register [CHANNELS];       // mode settings
   logic [CHANNELS-1:0] output_level_register;          // channel_output_bit
   logic [CHANNELS-1:0] output_enable_register;         // output_enable_bit
   logic [CHANNELS-1:0] output_polarity_register;       // output_polarity_bit
   logic [CHANNELS-1:0] output_mode_register;           // output_mode_bit
   logic [CHANNELS-1:0] filter_enable_register;         // input_filter_enable
   logic [CHANNELS-1:0] channel_running_flag;           // channel running
   logic [CHANNELS-1:0] load_pending;                   // waiting for first load
   logic [CHANNELS-1:0] pending_set;                    // delayed master set

   // ======================================================
   // combinational event terms
   logic [CHANNELS-1:0] tick;          // count clock per channel
   logic [CHANNELS-1:0] rise;          // input rising edge
   logic [CHANNELS-1:0] fall;          // input falling edge
   logic [CHANNELS-1:0] input_used;    // input selected by mode
   logic [CHANNELS-1:0] start_now;     // first count clock after start
   logic [CHANNELS-1:0] int_ev;        // channel_interrupt this cycle
   logic [CHANNELS-1:0] capture_ev;    // capture this cycle
   logic [CHANNELS-1:0] set_ev;        // output set request
   logic [CHANNELS-1:0] reset_ev;      // output reset request
   logic [CHANNELS-1:0] master_delay;  // delayed master interrupt applied
   logic wr_start;                     // write to start register
   logic wr_stop;                      // write to stop register

   assign wr_start = i_wr_en && (i_addr == TCI_START_OFS);
   assign wr_stop = i_wr_en && (i_addr == TCI_STOP_OFS);

   // ======================================================
   // input paths, one per channel
   genvar g;
   generate
      for (g = 0; g < CHANNELS; g++)
      begin : g_in
         assign input_used[g] = channel_mode_register[g][TCI_CCS] |
                                channel_mode_register[g][TCI_STS_HI] |
                                channel_mode_register[g][TCI_STS_LO];
         tci_input_path u_path
         (
            .i_clock(i_clock),
            .i_reset_n(i_reset_n),
            .i_pin(i_timer_input_pin[g]),
            .i_active(input_used[g]),
            .i_filter_en(filter_enable_register[g]),
            .o_rise(rise[g]),
            .o_fall(fall[g])
         );
      end
   endgenerate

   // ======================================================
   // channel events
   always_comb
   begin
      for (int i = 0; i < CHANNELS; i++)
      begin
         logic [2:0] md;
         logic periodic;
         logic trig_ok;
         md = mode_of(channel_mode_register[i]);
         periodic = (md == TCI_MD_INTERVAL) || (md == TCI_MD_EVENT);
         trig_ok = 1'b1;
         // count source: input edge or operating clock
         if (channel_mode_register[i][TCI_CCS])
            tick[i] = rise[i];
         else
            tick[i] = sel_tick(i, channel_mode_register[i], i_prescale_tick);
         // external start waits for an input edge
         if (channel_mode_register[i][TCI_STS_HI] | channel_mode_register[i][TCI_STS_LO])
            trig_ok = rise[i];
         start_now[i] = channel_running_flag[i] & load_pending[i] & tick[i] & trig_ok;
         capture_ev[i] = channel_running_flag[i] & ~load_pending[i] &
                         (md == TCI_MD_CAPTURE) & fall[i];
         int_ev[i] = 1'b0;
         if (start_now[i] && channel_mode_register[i][TCI_SIS] &&
             ((md == TCI_MD_INTERVAL) || (md == TCI_MD_CAPTURE)))
            int_ev[i] = 1'b1;
         else if (channel_running_flag[i] && !load_pending[i] && periodic && tick[i] &&
                  (channel_counter[i] == CNT_W'(TCI_CNT_ZERO)))
            int_ev[i] = 1'b1;
         else if (capture_ev[i])
            int_ev[i] = 1'b1;
      end
   end

   // slave set/reset sources
   always_comb
   begin
      for (int i = 0; i < CHANNELS; i++)
      begin
         // master set one count clock late
         master_delay[i] = pending_set[i] & tick[i];
         if (output_polarity_register[i])
         begin
            set_ev[i] = int_ev[i];
            reset_ev[i] = master_delay[i];
         end
         else
         begin
            set_ev[i] = master_delay[i];
            reset_ev[i] = int_ev[i];
         end
      end
   end

   // ======================================================
   // run control: running flag and first-load request
   always_ff @(posedge i_clock or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         channel_running_flag <= '0;
         load_pending <= '0;
      end
      else
      begin
         for (int i = 0; i < CHANNELS; i++)
         begin
            if (wr_start && i_wr_data[i])
            begin
               channel_running_flag[i] <= 1'b1;
               load_pending[i] <= 1'b1;
            end
            else if (wr_stop && i_wr_data[i])
            begin
               channel_running_flag[i] <= 1'b0;
               load_pending[i] <= 1'b0;
            end
            else if (start_now[i])
               load_pending[i] <= 1'b0;
         end
      end
   end

   // ======================================================
   // counters
   always_ff @(posedge i_clock or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         for (int i = 0; i < CHANNELS; i++)
            channel_counter[i] <= CNT_W'(TCI_CNT_ZERO);
      end
      else
      begin
         for (int i = 0; i < CHANNELS; i++)
         begin
            if (start_now[i])
               channel_counter[i] <= (mode_of(channel_mode_register[i]) == TCI_MD_CAPTURE) ? CNT_W'(TCI_CNT_ZERO)
                                     : reload_value_register[i];
            else if (channel_running_flag[i] && !load_pending[i])
            begin
               // capture mode counts up and restarts on capture
               if (mode_of(channel_mode_register[i]) == TCI_MD_CAPTURE)
               begin
                  if (capture_ev[i])
                     channel_counter[i] <= CNT_W'(TCI_CNT_ZERO);
                  else if (tick[i])
                     channel_counter[i] <= channel_counter[i] + CNT_W'(TCI_CNT_ONE);
               end
               else if (tick[i])
               begin
                  if (channel_counter[i] == CNT_W'(TCI_CNT_ZERO))
                     channel_counter[i] <= reload_value_register[i];
                  else
                     channel_counter[i] <= channel_counter[i] - CNT_W'(TCI_CNT_ONE);
               end
            end
         end
      end
   end

   // ======================================================
   // reload values: software writes, capture overrides
   always_ff @(posedge i_clock or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         for (int i = 0; i < CHANNELS; i++)
            reload_value_register[i] <= CNT_W'(TCI_CNT_ZERO);
      end
      else
      begin
         for (int i = 0; i < CHANNELS; i++)
         begin
            if (capture_ev[i])
               reload_value_register[i] <= channel_counter[i];
            else if (i_wr_en && ((i_addr & TCI_BANK_MASK) == TCI_RELOAD_BASE) &&
                     (bank_idx(i_addr) == i))
               reload_value_register[i] <= i_wr_data[CNT_W-1:0];
         end
      end
   end

   // ======================================================
   // configuration registers
   always_ff @(posedge i_clock or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         for (int i = 0; i < CHANNELS; i++)
            channel_mode_register[i] <= TCI_MODE_RESET;
         output_enable_register <= '0;
         output_polarity_register <= '0;
         output_mode_register <= '0;
         filter_enable_register <= '0;
      end
      else if (i_wr_en)
      begin
         for (int i = 0; i < CHANNELS; i++)
         begin
            if (((i_addr & TCI_BANK_MASK) == TCI_MODE_BASE) && (bank_idx(i_addr) == i))
               channel_mode_register[i] <= i_wr_data[15:0];
         end
         if (i_addr == TCI_ENABLE_OFS)
            output_enable_register <= i_wr_data[CHANNELS-1:0];
         if (i_addr == TCI_POLARITY_OFS)
            output_polarity_register <= i_wr_data[CHANNELS-1:0];
         if (i_addr == TCI_OMODE_OFS)
            output_mode_register <= i_wr_data[CHANNELS-1:0];
         if (i_addr == TCI_FILTER_OFS)
            filter_enable_register <= i_wr_data[CHANNELS-1:0];
      end
   end

   // ======================================================
   // delayed master set requests held until the slave's count clock
   always_ff @(posedge i_clock or negedge i_reset_n)
   begin
      if (!i_reset_n)
         pending_set <= '0;
      else
      begin
         for (int i = 0; i < CHANNELS; i++)
         begin
            // new master interrupt wins over consumption
            if (output_mode_register[i] && int_ev[master_of(i)] && (master_of(i) != i))
               pending_set[i] <= 1'b1;
            else if (master_delay[i] || !output_mode_register[i])
               pending_set[i] <= 1'b0;
         end
      end
   end

   // ======================================================
   // output pins
   always_ff @(posedge i_clock or negedge i_reset_n)
   begin
      if (!i_reset_n)
         output_level_register <= '0;
      else
      begin
         for (int i = 0; i < CHANNELS; i++)
         begin
            if (!output_enable_register[i])
            begin
               if (i_wr_en && (i_addr == TCI_LEVEL_OFS))
                  output_level_register[i] <= i_wr_data[i];
            end
            else if (!output_mode_register[i])
            begin
               if (int_ev[i])
                  output_level_register[i] <= ~output_level_register[i];
            end
            else if (reset_ev[i])
               output_level_register[i] <= 1'b0;
            else if (set_ev[i])
               output_level_register[i] <= 1'b1;
         end
      end
   end

   // ======================================================
   // pin and interrupt outputs
   always_ff @(posedge i_clock or negedge i_reset_n)
   begin
      if (!i_reset_n)
         o_channel_interrupt <= '0;
      else
         o_channel_interrupt <= int_ev;
   end

   assign o_channel_output = output_level_register;

   // ======================================================
   // read data, one cycle after the strobe, zero otherwise
   always_ff @(posedge i_clock or negedge i_reset_n)
   begin
      if (!i_reset_n)
         o_rd_data <= '0;
      else if (i_rd_en)
      begin
         o_rd_data <= '0;
         case (i_addr & TCI_BANK_MASK)
            TCI_MODE_BASE:
               if (bank_idx(i_addr) < CHANNELS)
                  o_rd_data <= TCI_DATA_W'(channel_mode_register[bank_idx(i_addr)]);
            TCI_RELOAD_BASE:
               if (bank_idx(i_addr) < CHANNELS)
                  o_rd_data <= TCI_DATA_W'(reload_value_register[bank_idx(i_addr)]);
            TCI_COUNT_BASE:
               if (bank_idx(i_addr) < CHANNELS)
                  o_rd_data <= TCI_DATA_W'(channel_counter[bank_idx(i_addr)]);
            default:
               case (i_addr)
                  TCI_STOP_OFS: o_rd_data <= TCI_DATA_W'(channel_running_flag);
                  TCI_LEVEL_OFS: o_rd_data <= TCI_DATA_W'(output_level_register);
                  TCI_ENABLE_OFS: o_rd_data <= TCI_DATA_W'(output_enable_register);
                  TCI_POLARITY_OFS: o_rd_data <= TCI_DATA_W'(output_polarity_register);
                  TCI_OMODE_OFS: o_rd_data <= TCI_DATA_W'(output_mode_register);
                  TCI_FILTER_OFS: o_rd_data <= TCI_DATA_W'(filter_enable_register);
                  default: o_rd_data <= '0;
               endcase
         endcase
      end
      else
         o_rd_data <= '0;
   end
   // bind software: the input path needs 3 (filter off) or 4 (on) cycles after enabling
endmodule : tci_timer_unit

`default_nettype wire

// ===== verif/tci_pin_model.sv
// Purpose: far side model driving the timer input pins
// Assumes: inputs stay unused unless a channel selects them
// Notes: level moves every cycle so no value stands still
`default_nettype none
module tci_pin_model
(
   input wire logic i_clock,
   input wire logic i_run,
   output logic [3:0] o_pin
);
   timeunit 1ns;
   timeprecision 1ns;
   // =========
   // stepping pattern, low when idle
   initial o_pin = 4'h0;
   always @(posedge i_clock) o_pin <= i_run ? o_pin + 4'h3 : 4'h0;
endmodule : tci_pin_model
`default_nettype wire

// ===== verif/tci_timer_unit_asserts.sv
// Purpose: port checks of the timer unit
// Assumes: channel 0 is a master channel
// Notes: output enable of channel 0 is tracked from writes
`default_nettype none
module tci_timer_unit_chk
   import tci_pkg::*;
#(
   parameter int CHANNELS = TCI_CHANNELS
)
(
   input wire logic i_clock,
   input wire logic i_reset_n,
   input wire logic [TCI_ADDR_W-1:0] i_addr,
   input wire logic [TCI_DATA_W-1:0] i_wr_data,
   input wire logic i_wr_en,
   input wire logic i_rd_en,
   input wire logic [TCI_DATA_W-1:0] o_rd_data,
   input wire logic [CHANNELS-1:0] o_channel_output,
   input wire logic [CHANNELS-1:0] o_channel_interrupt
);
   timeunit 1ns;
   timeprecision 1ns;
   // =========
   // tracked state
   logic en0; // channel 0 output enable
   logic lvl_wr; // write to the level register
   assign lvl_wr = i_wr_en && i_addr == TCI_LEVEL_OFS;
   always_ff @(posedge i_clock or negedge i_reset_n)
   begin
      if (!i_reset_n)
         en0 <= 1'b0;
      else if (i_wr_en && i_addr == TCI_ENABLE_OFS)
         en0 <= i_wr_data[0];
   end
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_reset_n);
   // =========
   // assertions
   rd_idle_a: assert property (!$past(i_rd_en) |-> o_rd_data == '0)
      else $error("read data not idle");
   out_toggle_a: assert property ($past(en0) && o_channel_interrupt[0] |-> $changed(o_channel_output[0]))
      else $error("pin did not toggle");
   en_hold_a: assert property ($past(en0) && !o_channel_interrupt[0] |-> $stable(o_channel_output[0]))
      else $error("enabled pin moved");
   dis_hold_a: assert property (!$past(en0) && !$past(lvl_wr) |-> $stable(o_channel_output[0]))
      else $error("disabled pin moved");
   wr_level_a: assert property (lvl_wr && !en0 |=> o_channel_output[0] == $past(i_wr_data[0]))
      else $error("level write lost");
   rd_level_a: assert property (i_rd_en && i_addr == TCI_LEVEL_OFS |=> o_rd_data[3:0] == $past(o_channel_output))
      else $error("level read wrong");
   start_rd_a: assert property (i_rd_en && i_addr == TCI_START_OFS |=> o_rd_data == '0)
      else $error("start bits read set");
   unmapped_rd_a: assert property (i_rd_en && i_addr == 8'h1c |=> o_rd_data == '0)
      else $error("unmapped read not zero");
endmodule : tci_timer_unit_chk
bind tci_timer_unit tci_timer_unit_chk #(.CHANNELS(CHANNELS)) tci_timer_unit_chk_inst (.i_clock(i_clock),
   .i_reset_n(i_reset_n), .i_addr(i_addr), .i_wr_data(i_wr_data), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en),
   .o_rd_data(o_rd_data), .o_channel_output(o_channel_output), .o_channel_interrupt(o_channel_interrupt));
`default_nettype wire

// ===== verif/test_timer_channel_io_interval.sv
// Purpose: self-checking bench of the timer unit
// Assumes: every prescaled tick fires each cycle
// Notes: channel 0 carries the interval cases
`default_nettype none
module test_timer_channel_io_interval import tci_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] e;} tci_row_s;
   logic i_clock = 1'b0;
   logic i_reset_n = 1'b0;
   logic [7:0] i_addr = 8'h00;
   logic [31:0] i_wr_data = 32'h0;
   logic i_wr_en = 1'b0;
   logic i_rd_en = 1'b0;
   logic [3:0] i_prescale_tick = 4'hf;
   logic pin_run = 1'b1;
   logic [3:0] pin;
   logic [31:0] rdat;
   logic [3:0] pout;
   logic [3:0] irq;
   int err_total = 0;
   int n_compared = 0;
   int d1, d0, n;
   // write, readback: enable, level, masked level, start, unmapped
   tci_row_s rows [6] = '{'{TCI_ENABLE_OFS, 32'h0, 32'h0}, '{TCI_LEVEL_OFS, 32'ha, 32'ha},
      '{TCI_ENABLE_OFS, 32'h3, 32'h3}, '{TCI_LEVEL_OFS, 32'h5, 32'h6},
      '{TCI_START_OFS, 32'h1, 32'h0}, '{8'h1c, 32'hff, 32'h0}};
   tci_timer_unit tci_timer_unit_inst (.i_clock(i_clock), .i_reset_n(i_reset_n), .i_addr(i_addr),
      .i_wr_data(i_wr_data), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .o_rd_data(rdat),
      .i_prescale_tick(i_prescale_tick), .i_timer_input_pin(pin), .o_channel_output(pout),
      .o_channel_interrupt(irq));
   tci_pin_model tci_pin_model_inst (.i_clock(i_clock), .i_run(pin_run), .o_pin(pin));
   initial
   begin
      forever #20 i_clock = ~i_clock;
   end
   // =========
   // shared tasks
   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      n_compared++;
      if (s !== e)
      begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      i_addr <= a;
      i_wr_data <= d;
      i_wr_en <= 1'b1;
      @(posedge i_clock);
      i_wr_en <= 1'b0;
      @(posedge i_clock);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
      i_addr <= a;
      i_rd_en <= 1'b1;
      @(posedge i_clock);
      i_rd_en <= 1'b0;
      #1 chk(nm, rdat, e);
      @(posedge i_clock);
   endtask : rd
   // cycles until the channel 0 interrupt, ends on the next edge
   task automatic wirq(output int k);
      k = 0;
      #1;
      while (irq[0] !== 1'b1 && k < 60)
      begin
         @(posedge i_clock);
         #1 k++;
      end
      chk("irq seen", irq[0], 1'b1);
      @(posedge i_clock);
   endtask : wirq
   task automatic give_verdict();
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : give_verdict
   // =========
   // main sequence
   initial
   begin
      repeat (4) @(posedge i_clock);
      i_reset_n <= 1'b1;
      rd(TCI_LEVEL_OFS, 32'h0, "level reset");
      foreach (rows[i])
      begin
         wr(rows[i].a, rows[i].w);
         rd(rows[i].a, rows[i].e, "row readback");
      end
      $display("register rows done");
      wr(TCI_ENABLE_OFS, 32'h1);
      wr(TCI_MODE_BASE, 32'h1);
      wr(TCI_RELOAD_BASE, 32'h2);
      wr(TCI_START_OFS, 32'h1);
      wirq(d1);
      wirq(n);
      chk("period", n, 2);
      wr(TCI_RELOAD_BASE, 32'h4);
      wirq(n);
      wirq(n);
      chk("new period", n, 4);
      $display("interval done");
      // restart without start interrupt, pin left alone
      wr(TCI_STOP_OFS, 32'h1);
      wr(TCI_ENABLE_OFS, 32'h0);
      wr(TCI_MODE_BASE, 32'h0);
      wr(TCI_START_OFS, 32'h1);
      wirq(d0);
      chk("start delay", d0, d1 + 5);
      $display("start select done");
      // input edges count in event mode; pin bit 0 flips every cycle, so one edge per 2 cycles
      wr(TCI_STOP_OFS, 32'h1);
      wr(TCI_MODE_BASE, 32'h1006);
      // start trigger lands two cycles after the input is enabled
      wr(TCI_START_OFS, 32'h1);
      wirq(n);
      wirq(n);
      chk("event period", n + 1, (4 + 1) * 2);
      // filter on: a pin that flips every cycle never holds two samples
      wr(TCI_FILTER_OFS, 32'h1);
      repeat (2) @(posedge i_clock);
      wr(TCI_START_OFS, 32'h1);
      n = 0;
      repeat (30)
      begin
         @(posedge i_clock);
         #1;
         if (irq[0] === 1'b1)
            n++;
      end
      chk("filtered irq", n, 0);
      $display("input path done");
      i_reset_n <= 1'b0;
      @(posedge i_clock);
      #1 chk("pin in reset", pout, 4'h0);
      @(posedge i_clock);
      i_reset_n <= 1'b1;
      rd(TCI_MODE_BASE, 32'h0, "mode reset");
      $display("reset done");
      give_verdict();
   end
   // watchdog, several times the expected run of about 135 cycles
   initial
   begin
      #40000;
      err_total++;
      give_verdict();
   end
endmodule : test_timer_channel_io_interval
`default_nettype wire
